// ==== opw_top.v ====
/*
 * Overlay phase and destination window register bank on an Avalon-MM slave.
 * Holds the initial phase, phase shift and window registers, and drives the
 * effective phases for the current field to the scaler.
 * Assumes a single 100 MHz clock, a synchronous active-high reset and a
 * display pipe that reports the field in progress on the same clock.
 * Reserved shift codes in use give no offset and raise a flag instead.
 */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "opw_consts.vh"

module opw_top #(
   parameter FRAC_W = 12,
   parameter WIN_W = 12
) (
   // Clock, reset and clock enable.
   input wire sys_clk_i,
   input wire rst_i,
   input wire clk_en_i,
   // Avalon-MM slave.
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // Display pipe status, same clock.
   input wire field_odd_i,
   input wire interlaced_i,
   // Effective phases to the scaler.
   output wire [FRAC_W+1:0] luma_vert_phase_o,
   output wire [FRAC_W+1:0] chroma_vert_phase_o,
   output wire [FRAC_W+1:0] luma_horiz_phase_o,
   output wire [FRAC_W+1:0] chroma_horiz_phase_o,
   // Window geometry on the attached pipe.
   output reg [WIN_W-1:0] win_top_o,
   output reg [WIN_W-1:0] win_left_o,
   output reg [WIN_W-1:0] win_height_o,
   output reg [WIN_W-1:0] win_width_o,
   // Raised while any selected shift code is reserved.
   output reg shift_reserved_o
);

   // Stored registers, one per mapped word other than status.
   // Luma vertical phases for both fields, reserved nibbles kept.
   reg [31:0] luma_vph_q;
   // Chroma vertical phases for both fields, reserved nibbles kept.
   reg [31:0] chroma_vph_q;
   // Chroma and luma horizontal phases; reserved nibbles read zero.
   reg [31:0] horiz_ph_q;
   // Six 4-bit phase-shift codes in the low three bytes.
   reg [31:0] shift_q;
   // Window top line and left pixel.
   reg [31:0] win_pos_q;
   // Window height in lines and width in pixels.
   reg [31:0] win_size_q;
   // Bus answer state; one wait cycle then the answer.
   reg ack_q;
   // Field in use, sampled so a mid-frame change lands cleanly.
   reg field_sel_q;
   // Reserved-code flags from each calculator.
   // Bit order: luma vertical, chroma vertical, luma and chroma horizontal.
   wire [3:0] res_w;
   // Merged byte-enable mask.
   // Built once and shared by every register write.
   wire [31:0] be_mask_w;

   // Byte enables widened to a bit mask.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_be
         // One enable bit spreads over its eight data bits.
         assign be_mask_w[gi*8+7:gi*8] = {8{avs_byteenable_i[gi]}};
      end
   endgenerate

   // Merge a write into a register under byte enables and a writable mask.
   // A lane left out by its enable, or a bit outside the mask, keeps its old value.
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [31:0] be_v;
      input [31:0] wmask;
      begin
         merge = (old_v & ~(be_v & wmask)) | (new_v & be_v & wmask);
      end
   endfunction

   // Pick one 12-bit fraction: the upper one at 31:20 or the lower one at 15:4.
   // The lower fraction also serves the luma horizontal phase.
   function [11:0] field12;
      input [31:0] r;
      input hi;
      begin
         field12 = hi ? r[`OPW_HI_HI:`OPW_HI_LO] : r[`OPW_LO_HI:`OPW_LO_LO];
      end
   endfunction

   // Waitrequest falls one cycle after a request so the answer comes from flops.
   // The idle cycle after each answer keeps a held request from being taken twice.
   // The cost is one lost cycle between back-to-back transfers.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         // Waitrequest stays high so nothing is answered during reset.
         ack_q <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else if (clk_en_i) begin
         if ((avs_read_i || avs_write_i) && !ack_q) begin
            // A fresh request is answered in the next cycle.
            ack_q <= 1'b1;
            avs_waitrequest_o <= 1'b0;
         end else begin
            // Answer given or bus idle: back to waiting.
            ack_q <= 1'b0;
            avs_waitrequest_o <= 1'b1;
         end
      end
   end

   // Register writes, taken on the edge where waitrequest is seen low.
   // An unmapped write falls through every branch and changes nothing.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         // All registers clear to zero.
         luma_vph_q <= `OPW_RST_REG;
         chroma_vph_q <= `OPW_RST_REG;
         horiz_ph_q <= `OPW_RST_REG;
         shift_q <= `OPW_RST_REG;
         win_pos_q <= `OPW_RST_REG;
         win_size_q <= `OPW_RST_REG;
      end else if (clk_en_i && ack_q && avs_write_i) begin
         if (avs_address_i == `OPW_OFF_LUMA_VPH) begin
            luma_vph_q <= merge(luma_vph_q, avs_writedata_i, be_mask_w, `OPW_MASK_VPH);
         end else if (avs_address_i == `OPW_OFF_CHROMA_VPH) begin
            // Chroma vertical phases, reserved nibbles kept as well.
            chroma_vph_q <= merge(chroma_vph_q, avs_writedata_i, be_mask_w, `OPW_MASK_VPH);
         end else if (avs_address_i == `OPW_OFF_HORIZ_PH) begin
            horiz_ph_q <= merge(horiz_ph_q, avs_writedata_i, be_mask_w, `OPW_MASK_HPH);
         end else if (avs_address_i == `OPW_OFF_SHIFT) begin
            shift_q <= merge(shift_q, avs_writedata_i, be_mask_w, `OPW_MASK_SHIFT);
         end else if (avs_address_i == `OPW_OFF_WIN_POS) begin
            win_pos_q <= merge(win_pos_q, avs_writedata_i, be_mask_w, `OPW_MASK_WIN);
         end else if (avs_address_i == `OPW_OFF_WIN_SIZE) begin
            // Sizes are stored as written; keeping them on the display is up to software.
            win_size_q <= merge(win_size_q, avs_writedata_i, be_mask_w, `OPW_MASK_WIN);
         end
      end
   end

   // Read data registered in the request cycle; unmapped addresses read zero.
   // The word is loaded every cycle, so it already stands when waitrequest falls.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (avs_address_i == `OPW_OFF_LUMA_VPH) begin
            // Luma vertical phase word.
            avs_readdata_o <= luma_vph_q;
         end else if (avs_address_i == `OPW_OFF_CHROMA_VPH) begin
            // Chroma vertical phase word.
            avs_readdata_o <= chroma_vph_q;
         end else if (avs_address_i == `OPW_OFF_HORIZ_PH) begin
            // Horizontal phase word.
            avs_readdata_o <= horiz_ph_q;
         end else if (avs_address_i == `OPW_OFF_SHIFT) begin
            // Shift code word.
            avs_readdata_o <= shift_q;
         end else if (avs_address_i == `OPW_OFF_WIN_POS) begin
            // Window position word.
            avs_readdata_o <= win_pos_q;
         end else if (avs_address_i == `OPW_OFF_WIN_SIZE) begin
            // Window size word.
            avs_readdata_o <= win_size_q;
         end else if (avs_address_i == `OPW_OFF_STATUS) begin
            // Live state: field in use and reserved-code flag.
            avs_readdata_o <= {30'h0000_0000, shift_reserved_o, field_sel_q};
         end else begin
            // Holes in the map read as zero.
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // Field selection sampled from the pipe.
   // The pins come from logic on this clock, so no synchroniser is needed.
   // A field change reaches the phase outputs two cycles later.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         // Field 0 until the pipe reports otherwise.
         field_sel_q <= 1'b0;
      end else if (clk_en_i) begin
         field_sel_q <= interlaced_i & field_odd_i;
      end
   end

   // Luma vertical phase for the current field.
   // Field 1 takes the upper fraction and its own shift code.
   opw_phase_calc #(.FRAC_W(FRAC_W)) u_luma_v (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .frac_i(field12(luma_vph_q, field_sel_q)),
      .code_i(field_sel_q ? shift_q[`OPW_SH_LUMA_F1+3:`OPW_SH_LUMA_F1]
                          : shift_q[`OPW_SH_LUMA_F0+3:`OPW_SH_LUMA_F0]),
      .phase_o(luma_vert_phase_o),
      .reserved_o(res_w[0])
   );

   // Chroma vertical phase for the current field.
   // Same selection as luma, with the chroma fractions and codes.
   opw_phase_calc #(.FRAC_W(FRAC_W)) u_chroma_v (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .frac_i(field12(chroma_vph_q, field_sel_q)),
      .code_i(field_sel_q ? shift_q[`OPW_SH_CHROMA_F1+3:`OPW_SH_CHROMA_F1]
                          : shift_q[`OPW_SH_CHROMA_F0+3:`OPW_SH_CHROMA_F0]),
      .phase_o(chroma_vert_phase_o),
      .reserved_o(res_w[1])
   );

   // Luma horizontal phase, same for every field.
   // Taken from the lower fraction; no field or buffer changes it.
   opw_phase_calc #(.FRAC_W(FRAC_W)) u_luma_h (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .frac_i(field12(horiz_ph_q, 1'b0)),
      .code_i(shift_q[`OPW_SH_LUMA_H+3:`OPW_SH_LUMA_H]),
      .phase_o(luma_horiz_phase_o),
      .reserved_o(res_w[2])
   );

   // Chroma horizontal phase.
   // Taken from the upper fraction of the horizontal word.
   opw_phase_calc #(.FRAC_W(FRAC_W)) u_chroma_h (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .frac_i(field12(horiz_ph_q, 1'b1)),
      .code_i(shift_q[`OPW_SH_CHROMA_H+3:`OPW_SH_CHROMA_H]),
      .phase_o(chroma_horiz_phase_o),
      .reserved_o(res_w[3])
   );

   // Window geometry and reserved flag, registered for the pipe.
   // Under 180 degree rotation the pipe reads top and left as the bottom
   // line and right edge of the unrotated window; nothing changes here.
   // Sizes are not checked against the display, which is a known limitation.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         // Outputs clear with the registers.
         win_top_o <= {WIN_W{1'b0}};
         win_left_o <= {WIN_W{1'b0}};
         win_height_o <= {WIN_W{1'b0}};
         win_width_o <= {WIN_W{1'b0}};
         shift_reserved_o <= 1'b0;
      end else if (clk_en_i) begin
         win_top_o <= win_pos_q[`OPW_WIN_HI_HI:`OPW_WIN_HI_LO];
         win_left_o <= win_pos_q[`OPW_WIN_LO_HI:`OPW_WIN_LO_LO];
         win_height_o <= win_size_q[`OPW_WIN_HI_HI:`OPW_WIN_HI_LO];
         win_width_o <= win_size_q[`OPW_WIN_LO_HI:`OPW_WIN_LO_LO];
         // The flag follows the codes in use now, not codes written earlier.
         shift_reserved_o <= |res_w;
      end
   end

endmodule // opw_top

`default_nettype wire

// ==== opw_consts.vh ====
/*
 * Constants for the overlay phase and window register bank: byte offsets,
 * field positions, reset values and shift codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef OPW_CONSTS_VH
`define OPW_CONSTS_VH

// Register byte offsets on the 32-bit slave.
`define OPW_OFF_LUMA_VPH 8'h1C
`define OPW_OFF_CHROMA_VPH 8'h20
`define OPW_OFF_HORIZ_PH 8'h24
`define OPW_OFF_SHIFT 8'h28
`define OPW_OFF_WIN_POS 8'h2C
`define OPW_OFF_WIN_SIZE 8'h30
// Status register holding the live reserved-code flag and the field in use.
`define OPW_OFF_STATUS 8'h34

// Reset values.
`define OPW_RST_REG 32'h0000_0000

// Writable bit masks; reserved bits of the vertical phase registers are kept.
`define OPW_MASK_VPH 32'hFFFF_FFFF
`define OPW_MASK_HPH 32'hFFF0_FFF0
`define OPW_MASK_SHIFT 32'h00FF_FFFF
`define OPW_MASK_WIN 32'h0FFF_0FFF

// Field positions (high and low bit of each 12-bit phase or window field).
`define OPW_HI_HI 31
`define OPW_HI_LO 20
`define OPW_LO_HI 15
`define OPW_LO_LO 4
`define OPW_WIN_HI_HI 27
`define OPW_WIN_HI_LO 16
`define OPW_WIN_LO_HI 11
`define OPW_WIN_LO_LO 0

// Shift code positions (low bit of each 4-bit code).
`define OPW_SH_LUMA_F0 20
`define OPW_SH_LUMA_F1 16
`define OPW_SH_LUMA_H 12
`define OPW_SH_CHROMA_F0 8
`define OPW_SH_CHROMA_F1 4
`define OPW_SH_CHROMA_H 0

// Shift codes.
`define OPW_CODE_ZERO 4'h0
`define OPW_CODE_PLUS1 4'h1
`define OPW_CODE_PLUS2 4'h2
`define OPW_CODE_MINUS1 4'hF

// Bus answer latency, in cycles of wait before the answer.
`define OPW_WAIT_CYCLES 1

`endif

// ==== opw_phase_calc.v ====
/*
 * Effective phase calculator: joins a 12-bit positive fraction with a 4-bit
 * shift code into a signed phase with two integer bits and twelve fraction bits.
 * Assumes a clock enable from the same domain and a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "opw_consts.vh"

module opw_phase_calc #(
   parameter FRAC_W = 12
) (
   // Clock and reset.
   input wire sys_clk_i,
   input wire rst_i,
   input wire clk_en_i,
   // Phase inputs.
   input wire [FRAC_W-1:0] frac_i,
   input wire [3:0] code_i,
   // Result: signed, range -1 up to but not including 2.
   output reg [FRAC_W+1:0] phase_o,
   output reg reserved_o
);

   // Integer part chosen by the code; reserved codes fall back to zero.
   reg [1:0] int_d;
   reg bad_d;

   // Decode of the shift code.
   always @* begin
      int_d = 2'h0;
      bad_d = 1'b0;
      case (code_i)
         `OPW_CODE_ZERO: int_d = 2'h0;
         `OPW_CODE_PLUS1: int_d = 2'h1;
         `OPW_CODE_MINUS1: int_d = 2'h3;
         `OPW_CODE_PLUS2: begin
            // clamp upper bound
            // Plus two with a nonzero fraction would reach two or more, so it saturates.
            int_d = 2'h1;
         end
         default: bad_d = 1'b1;
      endcase
   end

   // Registered result so the top outputs come from flip-flops.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         phase_o <= {(FRAC_W+2){1'b0}};
         reserved_o <= 1'b0;
      end else if (clk_en_i) begin
         if (code_i == `OPW_CODE_PLUS2 && frac_i != {FRAC_W{1'b0}}) begin
            // Largest value below two.
            phase_o <= {2'h1, {FRAC_W{1'b1}}};
         end else if (code_i == `OPW_CODE_PLUS2) begin
            // Exactly two is outside the range; the nearest legal value is used.
            phase_o <= {2'h1, {FRAC_W{1'b1}}};
         end else begin
            phase_o <= {int_d, frac_i};
         end
         reserved_o <= bad_d;
      end
   end

endmodule // opw_phase_calc

`default_nettype wire

// ==== opw_top_checker.sv ====
/*
 Checker for the overlay phase and window register bank.
 Assumes it is bound to opw_top and that no request is made while clk_en_i is low.
*/
`timescale 1ns/1ps
`default_nettype none
module opw_chk #(
   parameter FRAC_W = 12,
   parameter WIN_W = 12
) (
   // Clock, reset and bus.
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Outputs under watch.
   input wire logic [FRAC_W+1:0] luma_vert_phase_o,
   input wire logic [FRAC_W+1:0] chroma_vert_phase_o,
   input wire logic [FRAC_W+1:0] luma_horiz_phase_o,
   input wire logic [FRAC_W+1:0] chroma_horiz_phase_o,
   input wire logic [WIN_W-1:0] win_top_o
);
   // Answered reads and writes; only these may move state.
   wire rd_ack = avs_read_i && !avs_waitrequest_o;
   wire wr_ack = avs_write_i && !avs_waitrequest_o;
   wire hw = wr_ack && (avs_address_i == 8'h24 || avs_address_i == 8'h28);
   wire pw = wr_ack && avs_address_i == 8'h2C;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   answer_next_a: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
      else $error("request not answered next cycle");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   unmapped_zero_a: assert property (rd_ack && (avs_address_i < 8'h1C || avs_address_i > 8'h34)
      |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   horiz_resv_a: assert property (
      rd_ack && avs_address_i == 8'h24 |-> avs_readdata_o[19:16] == 4'h0 && avs_readdata_o[3:0] == 4'h0)
      else $error("horizontal reserved bits not zero");
   shift_resv_a: assert property (rd_ack && avs_address_i == 8'h28 |-> avs_readdata_o[31:24] == 8'h0)
      else $error("shift reserved bits not zero");
   win_resv_a: assert property (
      rd_ack && avs_address_i[7:2] inside {6'hB, 6'hC} |-> avs_readdata_o[31:28] == 4'h0
      && avs_readdata_o[15:12] == 4'h0) else $error("window reserved bits not zero");
   phase_range_a: assert property (luma_vert_phase_o[13:12] != 2'h2 && chroma_vert_phase_o[13:12] != 2'h2
      && luma_horiz_phase_o[13:12] != 2'h2 && chroma_horiz_phase_o[13:12] != 2'h2)
      else $error("phase below minus one");
   horiz_hold_a: assert property (!$stable(luma_horiz_phase_o) || !$stable(chroma_horiz_phase_o)
      |-> $past(hw, 1) || $past(hw, 2)) else $error("horizontal phase moved without write");
   top_hold_a: assert property (!$stable(win_top_o) |-> $past(pw, 1) || $past(pw, 2))
      else $error("window top moved without write");
   // Main scenarios reached.
   cover property (rd_ack && avs_address_i > 8'h34);
   cover property (luma_vert_phase_o[13:12] == 2'h3);
   cover property (win_top_o == 12'hFFF);
endmodule // opw_chk
bind opw_top opw_chk #(.FRAC_W(FRAC_W), .WIN_W(WIN_W)) opw_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .luma_vert_phase_o(luma_vert_phase_o), .chroma_vert_phase_o(chroma_vert_phase_o),
   .luma_horiz_phase_o(luma_horiz_phase_o), .chroma_horiz_phase_o(chroma_horiz_phase_o),
   .win_top_o(win_top_o));
`default_nettype wire

// ==== opw_top_tb_top.sv ====
/*
 Self-checking bench for the overlay phase and window bank.
 Assumes opw_top with default widths and its checker bound beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module opw_top_tb_top;
   // Design inputs, all given a value at time zero.
   logic sys_clk_i = 0, rst_i = 1, clk_en_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic field_odd_i = 0, interlaced_i = 0, shift_reserved_o, avs_waitrequest_o;
   logic [7:0] avs_address_i = 8'h0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd_v;
   logic [3:0] avs_byteenable_i = 4'hF, c;
   logic [13:0] lv, cv, lh, ch;
   logic [11:0] wt, wl, wh, ww;
   int fail_count = 0, tests_run = 0, cycles = 0;
   // Write table and the value each word must read back as.
   logic [31:0] wv [6] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF};
   logic [31:0] rv [6] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'hFFF0_FFF0, 32'h00FF_FFFF, 32'h0FFF_0FFF,
      32'h0FFF_0FFF};
   logic [3:0] cd [5] = '{4'h0, 4'h1, 4'h2, 4'hF, 4'h5};
   opw_top opw_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .field_odd_i(field_odd_i), .interlaced_i(interlaced_i), .luma_vert_phase_o(lv),
      .chroma_vert_phase_o(cv), .luma_horiz_phase_o(lh), .chroma_horiz_phase_o(ch),
      .win_top_o(wt), .win_left_o(wl), .win_height_o(wh), .win_width_o(ww),
      .shift_reserved_o(shift_reserved_o));
   always #5 sys_clk_i = ~sys_clk_i;
   // A hang ends the run as a mismatch; the whole run needs under two hundred cycles.
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         stop_test;
      end
   end
   // Compares a seen value with the expected one, unknowns never match.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One Avalon transfer held until waitrequest is sampled low; a gap edge follows.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_read_i <= !w;
      avs_write_i <= w;
      do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
      rd_v = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // Effective phase: offset per code, plus two saturates below two.
   function logic [13:0] eff(input logic [11:0] f, input logic [3:0] k);
      case (k)
         4'h1: eff = {2'h1, f};
         4'h2: eff = 14'h1FFF;
         4'hF: eff = {2'h3, f};
         default: eff = {2'h0, f};
      endcase
   endfunction
   // Phases settle one cycle after a write and two after a field change.
   task ph(input logic [13:0] a, input logic [13:0] b, input logic [13:0] h, input logic [13:0] g, input logic r);
      repeat (3) @(posedge sys_clk_i);
      chk(lv, a);
      chk(cv, b);
      chk(lh, h);
      chk(ch, g);
      chk(shift_reserved_o, r);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      for (int a = 8'h1C; a <= 8'h30; a += 4) begin
         bus(1'b0, a[7:0], 32'h0, 4'hF);
         chk(rd_v, 32'h0);
      end
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 8'h1C + 8'(4 * i), wv[i], 4'hF);
         bus(1'b0, 8'h1C + 8'(4 * i), 32'h0, 4'hF);
         chk(rd_v, rv[i]);
      end
      repeat (2) @(posedge sys_clk_i);
      chk({wt, wl}, 24'hFFF_FFF);
      chk({wh, ww}, 24'hFFF_FFF);
      bus(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 8'h3C, 32'h0, 4'hF);
      chk(rd_v, 32'h0);
      bus(1'b1, 8'h2C, 32'h0123_0456, 4'hF);
      bus(1'b1, 8'h2C, 32'hFFFF_FFFF, 4'h1);
      bus(1'b0, 8'h2C, 32'h0, 4'hF);
      chk(rd_v, 32'h0123_04FF);
      chk({wt, wl}, 24'h123_4FF);
      bus(1'b1, 8'h1C, 32'h123F_456F, 4'hF);
      bus(1'b1, 8'h20, 32'h789F_ABCF, 4'hF);
      bus(1'b1, 8'h24, 32'hDEF0_3210, 4'hF);
      foreach (cd[i]) begin
         c = cd[i];
         bus(1'b1, 8'h28, {8'h0, {6{c}}}, 4'hF);
         ph(eff(12'h456, c), eff(12'hABC, c), eff(12'h321, c), eff(12'hDEF, c), c > 4'h2 && c < 4'hF);
      end
      // Status shows the reserved flag raised by the last code.
      bus(1'b0, 8'h34, 32'h0, 4'hF);
      chk(rd_v, 32'h0000_0002);
      bus(1'b1, 8'h28, 32'h001F_0201, 4'hF);
      for (int k = 0; k < 4; k++) begin
         interlaced_i <= k[1];
         field_odd_i <= k[0];
         ph(k == 3 ? eff(12'h123, 4'hF) : eff(12'h456, 4'h1), k == 3 ? eff(12'h789, 4'h0) : eff(12'hABC, 4'h2),
            eff(12'h321, 4'h0), eff(12'hDEF, 4'h1), 1'b0);
      end
      // Field 1 is now in use and no code is reserved.
      bus(1'b0, 8'h34, 32'h0, 4'hF);
      chk(rd_v, 32'h0000_0001);
      // Clock enable low freezes the field in use and every phase.
      clk_en_i <= 1'b0;
      interlaced_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk(lv, {2'h3, 12'h123});
      clk_en_i <= 1'b1;
      ph(eff(12'h456, 4'h1), eff(12'hABC, 4'h2), eff(12'h321, 4'h0), eff(12'hDEF, 4'h1), 1'b0);
      // Chroma phases of minus 0.375 and minus 0.125 for the first two 4:1:0 lines.
      bus(1'b1, 8'h20, 32'hE00F_A00F, 4'hF);
      bus(1'b1, 8'h28, 32'h0000_0FF0, 4'hF);
      ph(eff(12'h456, 4'h0), {2'h3, 12'hA00}, eff(12'h321, 4'h0), eff(12'hDEF, 4'h0), 1'b0);
      interlaced_i <= 1'b1;
      ph(eff(12'h123, 4'h0), {2'h3, 12'hE00}, eff(12'h321, 4'h0), eff(12'hDEF, 4'h0), 1'b0);
      // A window that stays on the active display.
      bus(1'b1, 8'h30, 32'h0300_0400, 4'hF);
      bus(1'b0, 8'h30, 32'h0, 4'hF);
      chk(rd_v, 32'h0300_0400);
      chk({wh, ww}, 24'h300_400);
      // A mid-run reset clears every register and every output except waitrequest.
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk({lv, cv}, 28'h000_0000);
      chk({wt, wl}, 24'h000_000);
      chk({wh, ww}, 24'h000_000);
      bus(1'b0, 8'h28, 32'h0, 4'hF);
      chk(rd_v, 32'h0000_0000);
      stop_test;
   end
endmodule // opw_top_tb_top
`default_nettype wire
